// ---- pt8_defines.vh ----
// Behaviour
// R01 - count instruction clock through prescaler 1/4/16
// R02 - prescale field 00=1, 01=4, 1x=16
// R03 - postscale field n divides by n+1
// R04 - postscaler completion sets match flag
// R05 - count up, reload zero after period match
// R06 - period register readable writable, resets FFh
// R07 - count register read write, reset zero
// R08 - count/control write or reset clears dividers
// R09 - control write leaves count unchanged
// R10 - run bit gates counting, holds count
// R11 - match event drives pwm time base
// R12 - control bit seven reads zero
// R13 - sticky flag, irq needs all enables
`ifndef PT8_DEFINES_VH
`define PT8_DEFINES_VH
// register indices; the byte address on the bus is index times four
`define PT8_IDX_ICTL 8'h0b
`define PT8_IDX_PFLAG 8'h0c
`define PT8_IDX_COUNT 8'h11
`define PT8_IDX_TCTL 8'h12
`define PT8_IDX_PEN 8'h8c
`define PT8_IDX_PERIOD 8'h92
`define PT8_IDX_ICLR 8'h93
// control field positions
`define PT8_PRE_LO 0
`define PT8_PRE_HI 1
`define PT8_RUN_BIT 2
`define PT8_POST_LO 3
`define PT8_POST_HI 6
// flag and enable positions
`define PT8_MATCH_BIT 1
`define PT8_GIE_BIT 7
`define PT8_PERIPHERAL_IRQ_ENABLE_BIT 6
// reset values
`define PT8_PERIOD_RST 8'hff
`define PT8_ZERO8 8'h00
// instruction clock is core clock divided by four
`define PT8_ICLK_DIV 2'h3
// prescaler terminal counts
`define PT8_PRE1_LIM 4'h0
`define PT8_PRE4_LIM 4'h3
`define PT8_PRE16_LIM 4'hf
`endif

// ---- pt8_divider.v ----
`timescale 1ns/1ps
`default_nettype none
// generic clear-able modulo divider: pulse every (limit+1) steps
module pt8_divider #(
   parameter W = 4 // counter width
) (
   input wire pclk, // core clock
   input wire presetn, // async reset, low active
   input wire ce, // clock enable
   input wire clr, // synchronous clear
   input wire step, // advance request
   input wire [W-1:0] limit, // terminal count
   output wire done // completes on this step
);
   reg [W-1:0] cnt_r; // current count
   assign done = step && (cnt_r == limit);
   // count steps, wrap at limit
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= {W{1'b0}};
      end else if (ce) begin
         if (clr) begin
            cnt_r <= {W{1'b0}};
         end else if (done) begin
            cnt_r <= {W{1'b0}};
         end else if (step) begin
            cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // pt8_divider
`default_nettype wire

// ---- pt8_timer.v ----
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pt8_defines.vh"
////////////////////////////////////////////////////////////////////////
// 8-bit period timer with prescaler, postscaler and apb register file
module pt8_timer (
   input wire pclk, // core clock
   input wire presetn, // async reset, low active
   input wire ce, // clock enable, freezes state when low
   input wire psel, // apb select
   input wire penable, // apb enable
   input wire pwrite, // apb direction
   input wire [11:0] paddr, // apb byte address
   input wire [31:0] pwdata, // apb write data
   output reg [31:0] prdata, // apb read data
   output reg pready, // apb ready
   output reg pslverr, // apb error
   output reg match_pulse, // pwm time base event
   output reg irq // interrupt request level
);
////////////////////////////////////////////////////////////////////////
   reg [7:0] count_register_r; // running count
   reg [7:0] period_register_r; // period value
   reg [6:0] timer_control_r; // bit7 not implemented
   reg [7:0] flags_r; // peripheral flags
   reg [7:0] enables_r; // peripheral enables
   reg [7:0] ictl_r; // interrupt control
   reg [1:0] iclk_r; // instruction clock phase
   reg [31:0] rdata_nxt; // read mux
   reg hit_nxt; // address decoded
   wire setup = psel && !penable; // apb setup phase
   wire acc = psel && penable && pready; // apb completing access
   wire wr = acc && pwrite; // completed write
   wire [9:0] idx = paddr[11:2]; // register index
   wire word_ok = (paddr[1:0] == 2'h0); // aligned access
   wire wr_count = wr && word_ok && (idx == {2'h0, `PT8_IDX_COUNT});
   wire wr_tctl = wr && word_ok && (idx == {2'h0, `PT8_IDX_TCTL});
   wire wr_period = wr && word_ok && (idx == {2'h0, `PT8_IDX_PERIOD});
   wire wr_pflag = wr && word_ok && (idx == {2'h0, `PT8_IDX_PFLAG});
   wire wr_pen = wr && word_ok && (idx == {2'h0, `PT8_IDX_PEN});
   wire wr_ictl = wr && word_ok && (idx == {2'h0, `PT8_IDX_ICTL});
   wire wr_iclr = wr && word_ok && (idx == {2'h0, `PT8_IDX_ICLR});
   wire div_clr = wr_count || wr_tctl; // divider clear [R08]
   wire run = timer_control_r[`PT8_RUN_BIT]; // run bit
   wire iclk = (iclk_r == `PT8_ICLK_DIV); // instruction cycle tick [R01]
   wire [1:0] pre_sel = timer_control_r[`PT8_PRE_HI:`PT8_PRE_LO];
   wire [3:0] post_sel = timer_control_r[`PT8_POST_HI:`PT8_POST_LO];
   reg [3:0] pre_lim; // prescale terminal count
   wire pre_done; // prescaled increment
   wire is_match = pre_done && (count_register_r == period_register_r); // match [R05]
   wire post_done; // postscaler complete
////////////////////////////////////////////////////////////////////////
   // prescale decode
   always @* begin
      case (pre_sel)
         2'h0: pre_lim = `PT8_PRE1_LIM; // divide by one [R02]
         2'h1: pre_lim = `PT8_PRE4_LIM; // divide by four [R02]
         default: pre_lim = `PT8_PRE16_LIM; // divide by sixteen [R02]
      endcase
   end
   // prescaler, steps on instruction clock while running
   pt8_divider #(.W(4)) u_pre (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .clr(div_clr),
      .step(iclk && run), // [R10]
      .limit(pre_lim),
      .done(pre_done)
   ); // [R01]
   // postscaler, field n gives n+1 matches per flag
   pt8_divider #(.W(4)) u_post (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .clr(div_clr),
      .step(is_match),
      .limit(post_sel), // [R03]
      .done(post_done)
   );
////////////////////////////////////////////////////////////////////////
   // instruction clock phase, free running
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         iclk_r <= 2'h0;
      end else if (ce) begin
         iclk_r <= iclk_r + 2'h1;
      end
   end
   // count register
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_register_r <= `PT8_ZERO8; // [R07]
      end else if (ce) begin
         if (wr_count) begin
            count_register_r <= pwdata[7:0]; // [R07]
         end else if (is_match) begin
            count_register_r <= `PT8_ZERO8; // [R05]
         end else if (pre_done) begin
            count_register_r <= count_register_r + 8'h01; // [R05]
         end
      end
   end
   // control and period registers; control write keeps count [R09]
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_control_r <= 7'h00;
         period_register_r <= `PT8_PERIOD_RST; // [R06]
         enables_r <= `PT8_ZERO8;
         ictl_r <= `PT8_ZERO8;
      end else if (ce) begin
         if (wr_tctl) begin
            timer_control_r <= pwdata[6:0];
         end
         if (wr_period) begin
            period_register_r <= pwdata[7:0]; // [R06]
         end
         if (wr_pen) begin
            enables_r <= pwdata[7:0];
         end
         if (wr_ictl) begin
            ictl_r <= pwdata[7:0];
         end
      end
   end
   // sticky flags: set wins over clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_r <= `PT8_ZERO8;
      end else if (ce) begin
         if (wr_pflag) begin
            flags_r <= pwdata[7:0];
         end else if (wr_iclr) begin
            flags_r <= flags_r & ~pwdata[7:0];
         end
         if (post_done) begin
            flags_r[`PT8_MATCH_BIT] <= 1'b1; // [R04] [R13]
         end
      end
   end
////////////////////////////////////////////////////////////////////////
   // read mux
   always @* begin
      rdata_nxt = 32'h0;
      hit_nxt = word_ok;
      case (idx)
         {2'h0, `PT8_IDX_COUNT}: rdata_nxt = {24'h0, count_register_r};
         {2'h0, `PT8_IDX_TCTL}: rdata_nxt = {25'h0, timer_control_r}; // [R12]
         {2'h0, `PT8_IDX_PERIOD}: rdata_nxt = {24'h0, period_register_r};
         {2'h0, `PT8_IDX_PFLAG}: rdata_nxt = {24'h0, flags_r};
         {2'h0, `PT8_IDX_PEN}: rdata_nxt = {24'h0, enables_r};
         {2'h0, `PT8_IDX_ICTL}: rdata_nxt = {24'h0, ictl_r};
         {2'h0, `PT8_IDX_ICLR}: rdata_nxt = 32'h0; // write only
         default: hit_nxt = 1'b0; // unmapped
      endcase
   end
   // apb answer: no wait state, ready in first access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= setup;
         if (setup) begin
            // refused or write access returns zero data
            prdata <= (pwrite || !hit_nxt) ? 32'h0 : rdata_nxt;
            pslverr <= !hit_nxt;
         end else begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
         end
      end
   end
   // registered outputs: time base pulse and interrupt level
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_pulse <= 1'b0;
         irq <= 1'b0;
      end else if (ce) begin
         match_pulse <= is_match; // [R11]
         irq <= flags_r[`PT8_MATCH_BIT] && enables_r[`PT8_MATCH_BIT] &&
                ictl_r[`PT8_PERIPHERAL_IRQ_ENABLE_BIT] && ictl_r[`PT8_GIE_BIT]; // [R13]
      end
   end
endmodule // pt8_timer
`default_nettype wire

// ---- pt8_timer_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// port checks for the period timer
module pt8_timer_asserts (
   input wire logic pclk, // clock
   input wire logic presetn, // reset, low active
   input wire logic ce, // clock enable
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic match_pulse, // match event
   input wire logic irq // interrupt level
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_after_setup: assert property (psel && !penable && ce |=> pready)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_err_reads_zero: assert property (pslverr |-> prdata == 32'h0)
      else $error("refused read not zero");
   a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   a_upper_bits_zero: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_match_gap: assert property (match_pulse |=> !match_pulse [*3])
      else $error("match events too close");
endmodule // pt8_timer_asserts
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pt8_defines.vh"
module testbench;
   logic pclk, presetn, psel, penable, pwrite; // clock, reset, bus
   logic [11:0] paddr; // bus address
   logic [31:0] pwdata, rd; // write data, last read
   logic er; // last error
   logic ce; // clock enable
   wire [31:0] prdata; // read data
   wire pready, pslverr, match_pulse, irq; // outputs
   int num_errors, compares, c, i;
   pt8_timer u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .match_pulse(match_pulse), .irq(irq));
   initial begin
      pclk = 0;
      forever #50 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////
   task close_out;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // one apb transfer, register index times four
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= {2'b00, a, 2'b00}; pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin num_errors++; close_out; end
      rd = prdata; er = pslverr;
      psel <= 0; penable <= 0;
   endtask
   // edges up to the next match event
   task wm;
      c = 0;
      do begin @(posedge pclk); c++; end while (match_pulse !== 1'b1 && c < 2000);
      if (match_pulse !== 1'b1) begin num_errors++; close_out; end
   endtask
   ////////////////////////////////////////////////////////////////
   task t_reset;
      apb(0, `PT8_IDX_PERIOD, 0); chk(rd, 32'hff);
      apb(0, `PT8_IDX_COUNT, 0); chk(rd, 32'h0);
      apb(0, 8'h01, 0); chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      apb(1, `PT8_IDX_TCTL, 8'hff); apb(0, `PT8_IDX_TCTL, 0); chk(rd, 32'h7f);
   endtask
   task t_pre;
      apb(1, `PT8_IDX_PERIOD, 8'h03);
      for (i = 0; i < 4; i++) begin
         apb(1, `PT8_IDX_TCTL, 8'h04 | i);
         wm; wm; chk(c, (i == 0) ? 16 : (i == 1) ? 64 : 256);
      end
   endtask
   // clock enable low freezes the whole period for its length
   task t_freeze;
      apb(1, `PT8_IDX_PERIOD, 8'h03); apb(1, `PT8_IDX_TCTL, 8'h04);
      wm; ce <= 0; repeat (20) @(posedge pclk); ce <= 1;
      wm; chk(c, 16);
   endtask
   task t_hold;
      apb(1, `PT8_IDX_TCTL, 8'h00); apb(1, `PT8_IDX_COUNT, 8'h02);
      apb(0, `PT8_IDX_COUNT, 0); chk(rd, 32'h2);
      apb(1, `PT8_IDX_TCTL, 8'h78); repeat (40) @(posedge pclk);
      apb(0, `PT8_IDX_COUNT, 0); chk(rd, 32'h2);
   endtask
   // postscale 1:3, flag sticky, irq masking
   task t_irq;
      apb(1, `PT8_IDX_PERIOD, 8'h3f); apb(1, `PT8_IDX_ICLR, 8'h02);
      apb(1, `PT8_IDX_PEN, 8'h02); apb(1, `PT8_IDX_ICTL, 8'hc0);
      apb(1, `PT8_IDX_TCTL, 8'h14);
      wm; wm; apb(0, `PT8_IDX_PFLAG, 0); chk({irq, rd[1]}, 2'b00);
      wm; apb(0, `PT8_IDX_PFLAG, 0); chk({irq, rd[1]}, 2'b11);
      apb(1, `PT8_IDX_ICTL, 8'h40); repeat (2) @(posedge pclk); chk(irq, 0);
      apb(1, `PT8_IDX_ICTL, 8'hc0); apb(1, `PT8_IDX_ICLR, 8'h02);
      repeat (2) @(posedge pclk); chk(irq, 0);
   endtask
   initial begin
      num_errors = 0; compares = 0;
      presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; ce = 1;
      repeat (6) @(posedge pclk);
      presetn <= 1;
      t_reset; t_pre; t_freeze; t_hold; t_irq;
      close_out;
   end
endmodule // testbench
bind pt8_timer pt8_timer_asserts u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .match_pulse(match_pulse), .irq(irq));
`default_nettype wire
